// file: logic/dfb_pkg.sv
// Function
// - Branch saves next address, jumps via entry.
// - Branch may lag triggering instruction somewhat.
// - Fields: product, mask, data flags, free flags.
// - Data flags 35-47 sticky until software write.
// - Failed select or search sets flag 37.
// - Control vector gates flags 41 through 46.
// - Flags set regardless of their mask bits.
// - Product bit equals flag AND mask.
// - Enable bit 52 needed, cleared by branch.
// - Bit 51 is OR of products 4-15.
// - Bits 51 and 52 set branch at end.
// - Restored soft flag 35 with mask branches.
// - Conversion result out of range sets 39.
// - Flag 40 ORs 37-39, product 8 gated.
// - Flag 44 ORs 41-43, product 12 gated.
// - Divide fault sets 41, suppresses 42, 43.
// - Exponent above limit sets 42, forces indefinite.
// - Exponent below limit sets 43 unless fault.
// - Negative root operand sets 45, complements result.
// - Indefinite store or compare sets flag 46.
// - Status 53-55 initialized early, never branch.
// - Bit 58 scalar source, 59-63 vector duplicates.
// - Exit register gets zero top, next address.
`default_nettype none
package dfb_pkg;

  localparam int          REG_W        = 64;
  localparam int          ADDR_W       = 48;
  localparam int          MASK_LSB     = 16;
  localparam int          FLAG_LSB     = 32;
  localparam int          PROD_TRIG_LO = 4;
  localparam int          PROD_SOFT    = 3;
  localparam int          BIT_SOFT     = 35;
  localparam int          BIT_TIMER    = 36;
  localparam int          BIT_SELECT   = 37;
  localparam int          BIT_CONV     = 39;
  localparam int          BIT_OR_A     = 40;
  localparam int          BIT_DIVF     = 41;
  localparam int          BIT_EXPOVF   = 42;
  localparam int          BIT_MZERO    = 43;
  localparam int          BIT_OR_B     = 44;
  localparam int          BIT_SQRT     = 45;
  localparam int          BIT_INDEF    = 46;
  localparam int          BIT_BREAK    = 47;
  localparam int          BIT_ANY      = 51;
  localparam int          BIT_ENABLE   = 52;
  localparam int          BIT_STAT_LO  = 53;
  localparam int          BIT_SCALAR   = 58;
  localparam int          BIT_VEC_LO   = 59;
  localparam logic [63:0] WR_MASK      = 64'hfff0_eef8_fff8_0000;
  localparam logic [63:0] DFR_RESET    = 64'h0000_0000_0000_0000;
  localparam logic [15:0] EXP_OVF_64   = 16'h6fff;
  localparam logic [15:0] EXP_MZ_64    = 16'h9000;
  localparam logic [7:0]  EXP_OVF_32   = 8'h6f;
  localparam logic [7:0]  EXP_MZ_32    = 8'h90;
  localparam logic [15:0] EXIT_TOP     = 16'h0000;

endpackage
`default_nettype wire

// file: logic/dfb_flag_unit.sv
`timescale 1ns/1ps
`default_nettype none
module dfb_flag_unit
  import dfb_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  input  wire logic              instr_done_i,
  input  wire logic [ADDR_W-1:0] next_addr_i,
  input  wire logic [REG_W-1:0]  entry_reg_i,
  output logic                   branch_o,
  output logic [REG_W-1:0]       exit_reg_o,
  output logic [ADDR_W-1:0]      target_o,
  input  wire logic              load_i,
  input  wire logic [REG_W-1:0]  load_data_i,
  input  wire logic              alter_i,
  input  wire logic [5:0]        alter_bit_i,
  input  wire logic              alter_val_i,
  output logic [REG_W-1:0]       flag_reg_o,
  input  wire logic              timer_i,
  input  wire logic              breakpoint_i,
  input  wire logic              select_fail_i,
  input  wire logic              search_nomatch_i,
  input  wire logic              conv_valid_i,
  input  wire logic [REG_W-1:0]  conv_result_i,
  input  wire logic              arith_valid_i,
  input  wire logic              arith_vector_i,
  input  wire logic              arith_half_i,
  input  wire logic              cv_use_i,
  input  wire logic              cv_bit_i,
  input  wire logic [15:0]       exp_i,
  input  wire logic              src_indef_i,
  input  wire logic              div_i,
  input  wire logic              divisor_zero_i,
  input  wire logic              sqrt_i,
  input  wire logic              sqrt_neg_i,
  input  wire logic [ADDR_W-1:0] sqrt_root_i,
  output logic [ADDR_W-1:0]      sqrt_result_o,
  output logic                   force_indef_o,
  input  wire logic              indef_store_i,
  input  wire logic              cmp_indef_i,
  input  wire logic              status_init_i,
  input  wire logic              status_noop_i,
  input  wire logic [2:0]        status_set_i
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [REG_W-1:0]  dfr;
    logic              branch;
    logic [REG_W-1:0]  exit_reg;
    logic [ADDR_W-1:0] target;
    logic [ADDR_W-1:0] sqrt_result;
    logic              force_indef;
  } dfb_state_s;

  dfb_state_s st_r;
  dfb_state_s st_nxt;

  // ------------------------------------------------------------
  // Register view
  // ------------------------------------------------------------
  // Only writable bits are stored; summary bits are derived on read.
  function automatic logic [REG_W-1:0] dfb_view(input logic [REG_W-1:0] raw);
    logic [REG_W-1:0] v;
    v                  = raw & WR_MASK;
    v[BIT_OR_A]        = |v[BIT_CONV:BIT_SELECT];
    v[BIT_OR_B]        = |v[BIT_MZERO:BIT_DIVF];
    v[15:0]            = v[FLAG_LSB+:16] & v[MASK_LSB+:16];
    v[BIT_ANY]         = |v[15:PROD_TRIG_LO];
    return v;
  endfunction

  logic [REG_W-1:0] view;
  logic             trigger;
  logic             take;

  always_comb begin
    view    = dfb_view(st_r.dfr);
    // A restored soft flag with its mask also branches.
    trigger = view[BIT_ANY] | view[PROD_SOFT];
    take    = instr_done_i & trigger & view[BIT_ENABLE];
  end

  // ------------------------------------------------------------
  // Condition detection
  // ------------------------------------------------------------
  logic        cv_ok;
  logic        div_fault;
  logic        exp_ovf;
  logic        exp_mz;
  logic        conv_ovf;
  logic [5:0]  cv_flags;

  always_comb begin
    cv_ok     = ~cv_use_i | cv_bit_i;
    div_fault = arith_valid_i & div_i & divisor_zero_i & ~src_indef_i;
    if (arith_half_i) begin
      exp_ovf = $signed(exp_i[7:0]) > $signed(EXP_OVF_32);
      exp_mz  = $signed(exp_i[7:0]) < $signed(EXP_MZ_32);
    end else begin
      exp_ovf = $signed(exp_i) > $signed(EXP_OVF_64);
      exp_mz  = $signed(exp_i) < $signed(EXP_MZ_64);
    end
    exp_ovf  = arith_valid_i & exp_ovf & ~src_indef_i & ~div_fault;
    exp_mz   = arith_valid_i & exp_mz & ~div_fault;
    // Out of range when bits 63..47 are not a pure sign extension.
    conv_ovf = conv_valid_i & ~((&conv_result_i[63:47]) | ~(|conv_result_i[63:47]));
    cv_flags[0] = div_fault;
    cv_flags[1] = exp_ovf;
    cv_flags[2] = exp_mz;
    cv_flags[3] = 1'b0;
    cv_flags[4] = arith_valid_i & sqrt_i & sqrt_neg_i;
    cv_flags[5] = (arith_valid_i & (div_fault | exp_ovf | src_indef_i)) | indef_store_i
                  | cmp_indef_i;
    cv_flags    = cv_flags & {6{cv_ok}};
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic [REG_W-1:0] sets;
  logic [REG_W-1:0] base;

  always_comb begin
    st_nxt = st_r;
    sets   = '0;
    base   = st_r.dfr;

    if (take) begin
      base[BIT_ENABLE] = 1'b0;
    end
    if (status_init_i && !status_noop_i) begin
      base[BIT_STAT_LO+:3] = 3'h0;
    end
    // Software writes are the only way data flags 35-47 clear.
    if (load_i) begin
      base = load_data_i;
    end else if (alter_i) begin
      base[alter_bit_i] = alter_val_i;
    end

    // Hardware sets land after the software write, so a set wins.
    sets[BIT_TIMER]      = timer_i;
    sets[BIT_BREAK]      = breakpoint_i;
    sets[BIT_SELECT]     = select_fail_i | search_nomatch_i;
    sets[BIT_CONV]       = conv_ovf;
    sets[BIT_DIVF]       = cv_flags[0];
    sets[BIT_EXPOVF]     = cv_flags[1];
    sets[BIT_MZERO]      = cv_flags[2];
    sets[BIT_SQRT]       = cv_flags[4];
    sets[BIT_INDEF]      = cv_flags[5];
    sets[BIT_STAT_LO+:3] = (status_init_i & ~status_noop_i) ? status_set_i : 3'h0;
    sets[BIT_SCALAR]     = arith_valid_i & ~arith_vector_i & (div_i | sqrt_i)
                           & (|cv_flags);
    if (arith_valid_i && arith_vector_i) begin
      sets[BIT_VEC_LO+:5] = {cv_flags[5], cv_flags[4], cv_flags[2:0]};
    end

    st_nxt.dfr    = (base | sets) & WR_MASK;
    st_nxt.branch = take;
    if (take) begin
      st_nxt.exit_reg = {EXIT_TOP, next_addr_i};
      st_nxt.target   = entry_reg_i[ADDR_W-1:0];
    end

    if (arith_valid_i) begin
      st_nxt.force_indef = div_fault | exp_ovf;
      if (sqrt_i && sqrt_neg_i) begin
        st_nxt.sqrt_result = ADDR_W'(~sqrt_root_i + 1'b1);
      end else begin
        st_nxt.sqrt_result = sqrt_root_i;
      end
    end else begin
      st_nxt.force_indef = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_r.dfr         <= DFR_RESET;
      st_r.branch      <= 1'b0;
      st_r.exit_reg    <= '0;
      st_r.target      <= '0;
      st_r.sqrt_result <= '0;
      st_r.force_indef <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_comb begin
    flag_reg_o    = view;
    branch_o      = st_r.branch;
    exit_reg_o    = st_r.exit_reg;
    target_o      = st_r.target;
    sqrt_result_o = st_r.sqrt_result;
    force_indef_o = st_r.force_indef;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_product;
    @(posedge clock_i) disable iff (srst_i)
      flag_reg_o[15:0] == (flag_reg_o[47:32] & flag_reg_o[31:16]);
  endproperty
  a_product: assert property (p_product)
    else $error("Product field differs from flag and mask.");

  property p_any;
    @(posedge clock_i) disable iff (srst_i)
      flag_reg_o[BIT_ANY] == (|flag_reg_o[15:4]);
  endproperty
  a_any: assert property (p_any)
    else $error("Summary bit 51 differs from product OR.");

  property p_or_a;
    @(posedge clock_i) disable iff (srst_i)
      flag_reg_o[BIT_OR_A] == (|flag_reg_o[39:37]) && flag_reg_o[8] ==
      (flag_reg_o[24] & flag_reg_o[BIT_OR_A]);
  endproperty
  a_or_a: assert property (p_or_a)
    else $error("Flag 40 or product 8 wrong.");

  property p_take;
    @(posedge clock_i) disable iff (srst_i)
      instr_done_i && (flag_reg_o[BIT_ANY] || flag_reg_o[3]) && flag_reg_o[BIT_ENABLE]
      |=> branch_o;
  endproperty
  a_take: assert property (p_take)
    else $error("Branch not taken at instruction end.");

  property p_exit;
    @(posedge clock_i) disable iff (srst_i)
      instr_done_i && flag_reg_o[BIT_ANY] && flag_reg_o[BIT_ENABLE]
      |=> exit_reg_o == {16'h0000, $past(next_addr_i)}
          && target_o == $past(entry_reg_i[47:0]);
  endproperty
  a_exit: assert property (p_exit)
    else $error("Exit or target address wrong after branch.");

  property p_clear_en;
    @(posedge clock_i) disable iff (srst_i)
      branch_o && !$past(load_i) && !$past(alter_i) |-> !flag_reg_o[BIT_ENABLE];
  endproperty
  a_clear_en: assert property (p_clear_en)
    else $error("Enable bit not cleared by branch.");

  property p_sticky;
    @(posedge clock_i) disable iff (srst_i)
      flag_reg_o[BIT_SELECT] && !load_i && !alter_i |=> flag_reg_o[BIT_SELECT];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Flag 37 cleared without software write.");

  property p_nomatch;
    @(posedge clock_i) disable iff (srst_i)
      search_nomatch_i |=> flag_reg_o[BIT_SELECT];
  endproperty
  a_nomatch: assert property (p_nomatch)
    else $error("Failed search did not set flag 37.");

  property p_conv;
    @(posedge clock_i) disable iff (srst_i)
      conv_valid_i && ($signed(conv_result_i) > $signed(64'h0000_7fff_ffff_ffff))
      |=> flag_reg_o[BIT_CONV];
  endproperty
  a_conv: assert property (p_conv)
    else $error("Conversion overflow did not set flag 39.");

  property p_cv_gate;
    @(posedge clock_i) disable iff (srst_i)
      !flag_reg_o[BIT_DIVF] && cv_use_i && !cv_bit_i && !load_i && !alter_i
      |=> !flag_reg_o[BIT_DIVF];
  endproperty
  a_cv_gate: assert property (p_cv_gate)
    else $error("Masked element set divide fault flag.");

  property p_undef;
    @(posedge clock_i) disable iff (srst_i)
      (flag_reg_o & 64'h0007_0007_0007_0007) == 64'h0;
  endproperty
  a_undef: assert property (p_undef)
    else $error("Undefined bits read nonzero.");

  property p_or_b;
    @(posedge clock_i) disable iff (srst_i)
      flag_reg_o[BIT_OR_B] == (|flag_reg_o[43:41]) && flag_reg_o[12] ==
      (flag_reg_o[28] & flag_reg_o[BIT_OR_B]);
  endproperty
  a_or_b: assert property (p_or_b)
    else $error("Flag 44 or product 12 wrong.");

  property p_en_hold;
    @(posedge clock_i) disable iff (srst_i)
      !flag_reg_o[BIT_ENABLE] && !load_i && !alter_i |=> !flag_reg_o[BIT_ENABLE];
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("Enable bit set without software write.");

  property p_no_branch;
    @(posedge clock_i) disable iff (srst_i)
      !instr_done_i || !flag_reg_o[BIT_ENABLE] |=> !branch_o;
  endproperty
  a_no_branch: assert property (p_no_branch)
    else $error("Branch taken without enable or instruction end.");

  property p_div_supp;
    @(posedge clock_i) disable iff (srst_i)
      arith_valid_i && div_i && divisor_zero_i && !src_indef_i && !flag_reg_o[BIT_EXPOVF]
      && !load_i && !alter_i |=> force_indef_o && !flag_reg_o[BIT_EXPOVF];
  endproperty
  a_div_supp: assert property (p_div_supp)
    else $error("Divide fault handling wrong.");

  property p_sqrt;
    @(posedge clock_i) disable iff (srst_i)
      arith_valid_i && sqrt_i && sqrt_neg_i
      |=> (sqrt_result_o + $past(sqrt_root_i)) == 48'h0;
  endproperty
  a_sqrt: assert property (p_sqrt)
    else $error("Negative root result is not the complement.");

  property p_status_hold;
    @(posedge clock_i) disable iff (srst_i)
      status_init_i && status_noop_i && !load_i && !alter_i
      |=> flag_reg_o[55:53] == $past(flag_reg_o[55:53]);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("Status bits changed by a no-op.");

  property p_cmp_indef;
    @(posedge clock_i) disable iff (srst_i)
      cmp_indef_i && (!cv_use_i || cv_bit_i) |=> flag_reg_o[BIT_INDEF];
  endproperty
  a_cmp_indef: assert property (p_cmp_indef)
    else $error("Indefinite compare did not set flag 46.");

endmodule
`default_nettype wire

// file: bench/dfb_regfile_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------------
// Register file slots that hold the branch entry and exit addresses.
// --------------------------------------------------------------------
module dfb_regfile_model #(
  parameter logic [63:0] ENTRY = 64'hffff_0000_0000_4000
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        branch_i,
  input  wire logic [63:0] exit_i,
  output logic [63:0]      entry_o,
  output logic [63:0]      reg_exit_o
);
  assign entry_o = ENTRY;

  // Register 01 takes the exit value only when the branch is taken.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      reg_exit_o <= 64'h0;
    end else if (branch_i) begin
      reg_exit_o <= exit_i;
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_data_flag_branch_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_data_flag_branch_unit
  import dfb_pkg::*;
;
  logic clock_i, srst_i, instr_done_i, load_i, alter_i, alter_val_i, timer_i, breakpoint_i;
  logic select_fail_i, search_nomatch_i, conv_valid_i, arith_valid_i, arith_vector_i;
  logic arith_half_i, cv_use_i, cv_bit_i, src_indef_i, div_i, divisor_zero_i, sqrt_i;
  logic sqrt_neg_i, indef_store_i, cmp_indef_i, status_init_i, status_noop_i;
  logic branch_o, force_indef_o;
  logic [ADDR_W-1:0] next_addr_i, target_o, sqrt_root_i, sqrt_result_o;
  logic [REG_W-1:0]  entry_reg_i, exit_reg_o, load_data_i, flag_reg_o, conv_result_i, reg01;
  logic [5:0]        alter_bit_i;
  logic [15:0]       exp_i;
  logic [2:0]        status_set_i;
  int                bad_count = 0;
  int                checks_done = 0;

  dfb_flag_unit dut (.clock_i, .srst_i, .instr_done_i, .next_addr_i, .entry_reg_i, .branch_o,
    .exit_reg_o, .target_o, .load_i, .load_data_i, .alter_i, .alter_bit_i, .alter_val_i,
    .flag_reg_o, .timer_i, .breakpoint_i, .select_fail_i, .search_nomatch_i, .conv_valid_i,
    .conv_result_i, .arith_valid_i, .arith_vector_i, .arith_half_i, .cv_use_i, .cv_bit_i,
    .exp_i, .src_indef_i, .div_i, .divisor_zero_i, .sqrt_i, .sqrt_neg_i, .sqrt_root_i,
    .sqrt_result_o, .force_indef_o, .indef_store_i, .cmp_indef_i, .status_init_i,
    .status_noop_i, .status_set_i);

  dfb_regfile_model model (.clock_i, .srst_i, .branch_i(branch_o), .exit_i(exit_reg_o),
    .entry_o(entry_reg_i), .reg_exit_o(reg01));

  always #2.5 clock_i = ~clock_i;

  // --------------------------------------------------------------------
  // Shared helpers.
  // --------------------------------------------------------------------
  task tick;
    @(posedge clock_i);
  endtask

  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [63:0] d);
    tick; load_i <= 1'b1; load_data_i <= d;
    tick; load_i <= 1'b0; #1;
  endtask

  task alt(input logic [5:0] b, input logic v);
    tick; alter_i <= 1'b1; alter_bit_i <= b; alter_val_i <= v;
    tick; alter_i <= 1'b0; #1;
  endtask

  task done_at(input logic [47:0] a);
    tick; instr_done_i <= 1'b1; next_addr_i <= a;
    tick; instr_done_i <= 1'b0; #1;
  endtask

  task arith;
    tick; arith_valid_i <= 1'b1;
    tick; arith_valid_i <= 1'b0; #1;
  endtask

  // --------------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------------
  task t_fields;
    wr('1); chk(flag_reg_o, 64'hfff8_fff8_fff8_fff8);
    wr(64'h0); chk(flag_reg_o, 64'h0);
    wr(64'h0000_0040_0000_0000); chk(flag_reg_o, 64'h0000_0140_0000_0000);
    alt(6'd24, 1'b1); chk(flag_reg_o, 64'h0008_0140_0100_0100);
    alt(6'd51, 1'b0); chk(flag_reg_o, 64'h0008_0140_0100_0100);
    wr(64'h0000_0200_1000_0000); chk(flag_reg_o, 64'h0008_1200_1000_1000);
    $display("test fields done");
  endtask

  task t_sticky;
    wr(64'h0000_0000_0100_0000);
    tick; search_nomatch_i <= 1'b1;
    tick; search_nomatch_i <= 1'b0;
    tick; tick; #1 chk(flag_reg_o, 64'h0008_0120_0100_0100);
    alt(6'd37, 1'b0); chk(flag_reg_o[37], 1'b0);
    tick; select_fail_i <= 1'b1;
    tick; select_fail_i <= 1'b0; #1 chk(flag_reg_o[37], 1'b1);
    $display("test sticky done");
  endtask

  task t_branch;
    wr(64'h0000_0000_0010_0000);
    tick; timer_i <= 1'b1;
    tick; timer_i <= 1'b0;
    done_at(48'h1234_5678_9ab0); chk(branch_o, 1'b0);
    alt(6'd52, 1'b1);
    done_at(48'h1234_5678_9ab0); chk(branch_o, 1'b1);
    chk(exit_reg_o, 64'h0000_1234_5678_9ab0);
    chk(target_o, 48'h0000_0000_4000);
    chk(flag_reg_o[52], 1'b0);
    tick; #1 chk(branch_o, 1'b0);
    chk(reg01, 64'h0000_1234_5678_9ab0);
    wr(64'h0010_0008_0008_0000);
    done_at(48'h0000_0000_0040); chk(branch_o, 1'b1);
    $display("test branch done");
  endtask

  task t_arith;
    wr(64'h0);
    tick; div_i <= 1'b1; divisor_zero_i <= 1'b1; cv_use_i <= 1'b1; cv_bit_i <= 1'b0;
    arith; chk(flag_reg_o[41], 1'b0);
    tick; cv_bit_i <= 1'b1;
    arith; chk(force_indef_o, 1'b1);
    chk(flag_reg_o[43:41], 3'b001);
    chk(flag_reg_o[58], 1'b1);
    wr(64'h0);
    tick; div_i <= 1'b0; divisor_zero_i <= 1'b0; cv_use_i <= 1'b0; exp_i <= 16'h6fff;
    arith; chk(flag_reg_o[42], 1'b0);
    tick; exp_i <= 16'h7000;
    arith; chk(flag_reg_o[42], 1'b1);
    chk(force_indef_o, 1'b1);
    wr(64'h0);
    tick; arith_half_i <= 1'b1; exp_i <= 16'h0070;
    arith; chk(flag_reg_o[42], 1'b1);
    wr(64'h0);
    tick; src_indef_i <= 1'b1;
    arith; chk(flag_reg_o[46:42], 5'b10000);
    wr(64'h0);
    tick; exp_i <= 16'h9000; arith_half_i <= 1'b0; src_indef_i <= 1'b0;
    arith; chk(flag_reg_o[43], 1'b0);
    tick; exp_i <= 16'h8fff;
    arith; chk(flag_reg_o[43], 1'b1);
    wr(64'h0);
    tick; exp_i <= 16'h0; sqrt_i <= 1'b1; sqrt_neg_i <= 1'b1; sqrt_root_i <= 48'h10;
    arith_vector_i <= 1'b1;
    arith; chk(sqrt_result_o, 48'hffff_ffff_fff0);
    chk(flag_reg_o[45], 1'b1);
    chk(flag_reg_o[62], 1'b1);
    wr(64'h0);
    tick; sqrt_i <= 1'b0; sqrt_neg_i <= 1'b0; arith_vector_i <= 1'b0; indef_store_i <= 1'b1;
    tick; indef_store_i <= 1'b0; #1 chk(flag_reg_o[46], 1'b1);
    $display("test arith done");
  endtask

  task t_misc;
    wr(64'h0);
    tick; conv_valid_i <= 1'b1; conv_result_i <= 64'h0000_7fff_ffff_ffff;
    tick; conv_result_i <= 64'hffff_8000_0000_0000; #1 chk(flag_reg_o[39], 1'b0);
    tick; conv_result_i <= 64'h0000_8000_0000_0000; #1 chk(flag_reg_o[39], 1'b0);
    tick; conv_valid_i <= 1'b0; #1 chk(flag_reg_o[39], 1'b1);
    wr(64'h0);
    tick; status_init_i <= 1'b1; status_set_i <= 3'b101;
    tick; status_init_i <= 1'b0; #1 chk(flag_reg_o[55:53], 3'b101);
    tick; status_init_i <= 1'b1; status_noop_i <= 1'b1; status_set_i <= 3'b010;
    tick; status_init_i <= 1'b0; #1 chk(flag_reg_o[55:53], 3'b101);
    chk(flag_reg_o[51], 1'b0);
    alt(6'd52, 1'b1);
    done_at(48'h0000_0000_0080); chk(branch_o, 1'b0);
    wr(64'h0);
    tick; breakpoint_i <= 1'b1; cmp_indef_i <= 1'b1;
    tick; breakpoint_i <= 1'b0; cmp_indef_i <= 1'b0;
    #1 chk(flag_reg_o[47:46], 2'b11);
    $display("test misc done");
  endtask

  // --------------------------------------------------------------------
  // Closing and main sequence.
  // --------------------------------------------------------------------
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #25000;
    bad_count++;
    stop_test;
  end

  initial begin
    clock_i = 1'b0;
    srst_i = 1'b1;
    {instr_done_i, load_i, alter_i, alter_val_i, timer_i, breakpoint_i, select_fail_i} = '0;
    {search_nomatch_i, conv_valid_i, arith_valid_i, arith_vector_i, arith_half_i} = '0;
    {cv_use_i, cv_bit_i, src_indef_i, div_i, divisor_zero_i, sqrt_i, sqrt_neg_i} = '0;
    {indef_store_i, cmp_indef_i, status_init_i, status_noop_i, status_set_i} = '0;
    {next_addr_i, sqrt_root_i, load_data_i, conv_result_i, alter_bit_i, exp_i} = '0;
    repeat (4) tick;
    srst_i <= 1'b0;
    #1 chk(flag_reg_o, 64'h0);
    t_fields;
    t_sticky;
    t_branch;
    t_arith;
    t_misc;
    stop_test;
  end
endmodule
`default_nettype wire
